/* rtl/fidsg_pkg.sv */
// Shared constants and types of the identification read and suspend gate.
package fidsg_pkg;

  // Opcodes that the block decodes itself.
  localparam logic [7:0] OP_DUAL_ID = 8'h92;   // Dual line identification read.
  localparam logic [7:0] OP_QUAD_ID = 8'h94;   // Quad line identification read.
  localparam logic [7:0] OP_STD_ID  = 8'h9f;   // Standard identification read.
  localparam logic [7:0] OP_SUSPEND = 8'h75;   // Program or erase suspend.
  localparam logic [7:0] OP_RESUME  = 8'h7a;   // Program or erase resume.
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND    = 8'h06;   // Write enable command.
  localparam logic [7:0] OP_WRITE_DISABLE_COMMAND    = 8'h04;   // Write disable command.

  // Address byte that selects device identity first.
  localparam logic [7:0] ORD_DEV_FIRST = 8'h01;

  // Rising edge counts that end the opcode and address phases.
  localparam logic [5:0] OP_LAST   = 6'h07;    // Eighth edge of the opcode.
  localparam logic [5:0] DUAL_LAST = 6'h13;    // Twelve dual edges later.
  localparam logic [5:0] QUAD_LAST = 6'h0d;    // Six quad edges later.

  // Output enable masks for the data lines.
  localparam logic [3:0] OE_STD  = 4'h2;       // Only data_line_1 drives.
  localparam logic [3:0] OE_DUAL = 4'h3;       // Lines 0 and 1 drive.
  localparam logic [3:0] OE_QUAD = 4'hf;       // All four lines drive.

  // Suspend latencies, in nanoseconds, and the core clock rate.
  localparam int PSL_NS  = 20000;              // program_suspend_latency.
  localparam int ESL_NS  = 20000;              // erase_suspend_latency.
  localparam int CLK_MHZ = 200;                // Core clock rate.
  localparam int PSL_CYC = (PSL_NS * CLK_MHZ + 999) / 1000;
  localparam int ESL_CYC = (ESL_NS * CLK_MHZ + 999) / 1000;

  // Kind of the running array operation.
  localparam logic [1:0] KIND_PAGE = 2'h0;     // Page program.
  localparam logic [1:0] KIND_SEC  = 2'h1;     // 4KB sector erase.
  localparam logic [1:0] KIND_B32  = 2'h2;     // 32KB block erase.
  localparam logic [1:0] KIND_B64  = 2'h3;     // 64KB block erase.

  // Lowest address bit that still names the protected region.
  localparam int PAGE_LSB = 8;
  localparam int SEC_LSB  = 12;
  localparam int B32_LSB  = 15;
  localparam int B64_LSB  = 16;

  // Core states, Gray coded along idle, busy, wait, suspended.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_WAIT = 2'h3,
    ST_SUSP = 2'h2
  } fidsg_st_t;

  // Link states, Gray coded along opcode, address, output.
  typedef enum logic [1:0] {
    LK_OP  = 2'h0,
    LK_ADR = 2'h1,
    LK_OUT = 2'h3,
    LK_OFF = 2'h2
  } fidsg_lk_t;

  // Which identification read the link serves.
  typedef enum logic [1:0] {
    ID_STD  = 2'h0,
    ID_DUAL = 2'h1,
    ID_QUAD = 2'h2
  } fidsg_id_t;

  // Status word; suspend_flag sits in bit 15.
  typedef struct packed {
    logic        suspend_flag;
    logic [12:0] rsv;
    logic        write_enable_latch;
    logic        write_in_progress;
  } fidsg_sr_t;

  // Verdict on one opcode seen by the core.
  typedef struct packed {
    logic       ok;
    logic       drop;
    logic [7:0] op;
  } fidsg_cmd_t;

endpackage : fidsg_pkg

/* rtl/fidsg_top.sv */
`timescale 1ns/1ps
module fidsg_top #(
  parameter int         PSL_CYCLES = fidsg_pkg::PSL_CYC, // Program suspend wait.
  parameter int         ESL_CYCLES = fidsg_pkg::ESL_CYC, // Erase suspend wait.
  parameter int         CW         = 13,                 // Latency counter width.
  parameter logic [7:0] MAKER_ID   = 8'h3c,              // Arbitrary value.
  parameter logic [15:0] DEV_ID    = 16'h4d2e,           // Arbitrary value.
  parameter logic [7:0] SHORT_ID   = 8'h6b               // Arbitrary value.
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  sclk,
  input  wire logic                  chip_select_n,
  input  wire logic [3:0]            dq_i,
  output logic      [3:0]            dq_o,
  output logic      [3:0]            dq_oe,
  input  wire logic                  op_start,
  input  wire logic [1:0]            op_kind,
  input  wire logic [23:0]           op_addr,
  input  wire logic                  op_done,
  input  wire logic [23:0]           rd_addr,
  output logic                       rd_ok,
  output logic                       hold,
  output fidsg_pkg::fidsg_sr_t       sr_o,
  output fidsg_pkg::fidsg_cmd_t      cmd_o
);

  // Counters must hold the largest latency.
  if (PSL_CYCLES < 1 || ESL_CYCLES < 1 || PSL_CYCLES >= 2**CW || ESL_CYCLES >= 2**CW)
  begin : g_chk
    $error("Suspend latency does not fit the counter");
  end

  // Link logic is reset whenever chip select is high, so each frame starts clean.
  logic                  lrst_n;
  assign lrst_n = rst_n & ~chip_select_n;

  fidsg_pkg::fidsg_lk_t  lk_reg;      // Link phase.
  fidsg_pkg::fidsg_id_t  kd_reg;      // Which read is served.
  logic [5:0]            cnt_reg;     // Rising edges in this frame.
  logic [7:0]            sh_reg;      // Opcode, then address byte.
  logic [7:0]            fop_reg;     // Last opcode, held for the core.
  logic                  tgl_reg;     // Flips once per opcode.
  logic                  blk_s1;      // Busy level, first sync stage.
  logic                  blk_s2;      // Busy level, usable stage.
  logic [23:0]           ow_reg;      // Identity bits still to send.
  logic                  go_reg;      // Output has started.
  logic [7:0]            opc;         // Opcode as it completes.
  logic [23:0]           init_w;      // First identity word.
  logic [23:0]           cur_w;       // Word sent this falling edge.

  fidsg_pkg::fidsg_st_t  st_reg;      // Core state.
  logic [1:0]            kind_reg;    // Kind of array operation.
  logic [23:0]           base_reg;    // Address of array operation.
  logic [CW-1:0]         lat_reg;     // Remaining latency.
  logic                  tg_s1;       // Toggle, first sync stage.
  logic                  tg_s2;       // Toggle, second sync stage.
  logic                  tg_s3;       // Toggle, edge reference.
  logic                  blk_reg;     // Identification reads blocked.
  logic                  ev;          // New opcode seen.
  logic                  acc;         // Opcode acceptable now.
  logic                  hit;         // Read falls in frozen region.
  logic                  ers;         // Suspended operation is an erase.
  logic                  wait_end;    // Suspend latency has run out.
  logic                  resume;      // Accepted resume.

  assign opc = {sh_reg[6:0], dq_i[0]};

  // Opcode and address shift on rising edges; an unknown opcode parks the link.
  always_ff @(posedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      lk_reg  <= fidsg_pkg::LK_OP;
      kd_reg  <= fidsg_pkg::ID_STD;
      cnt_reg <= 6'h00;
      sh_reg  <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_reg + 6'h01;
      case (lk_reg)
        fidsg_pkg::LK_OP:
        begin
          sh_reg <= opc;
          if (cnt_reg == fidsg_pkg::OP_LAST)
          begin
            // A running program or erase blocks the identity reads.
            if (blk_s2)
              lk_reg <= fidsg_pkg::LK_OFF;
            else if (opc == fidsg_pkg::OP_DUAL_ID)
            begin
              lk_reg <= fidsg_pkg::LK_ADR;
              kd_reg <= fidsg_pkg::ID_DUAL;
            end
            else if (opc == fidsg_pkg::OP_QUAD_ID)
            begin
              lk_reg <= fidsg_pkg::LK_ADR;
              kd_reg <= fidsg_pkg::ID_QUAD;
            end
            else if (opc == fidsg_pkg::OP_STD_ID)
              lk_reg <= fidsg_pkg::LK_OUT;
            else
              lk_reg <= fidsg_pkg::LK_OFF;
          end
        end
        fidsg_pkg::LK_ADR:
        begin
          // Dummies and address come on two or four lines, high line first.
          if (kd_reg == fidsg_pkg::ID_DUAL)
          begin
            sh_reg <= {sh_reg[5:0], dq_i[1:0]};
            if (cnt_reg == fidsg_pkg::DUAL_LAST)
              lk_reg <= fidsg_pkg::LK_OUT;
          end
          else
          begin
            sh_reg <= {sh_reg[3:0], dq_i};
            if (cnt_reg == fidsg_pkg::QUAD_LAST)
              lk_reg <= fidsg_pkg::LK_OUT;
          end
        end
        default:
          lk_reg <= lk_reg;
      endcase
    end
  end

  // Opcode hand-off survives chip select, so the toggle never flips spuriously.
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fop_reg <= 8'h00;
      tgl_reg <= 1'b0;
    end
    else if (!chip_select_n && lk_reg == fidsg_pkg::LK_OP && cnt_reg == fidsg_pkg::OP_LAST)
    begin
      fop_reg <= opc;
      tgl_reg <= ~tgl_reg;
    end
  end

  // Busy level enters the link domain; the opcode phase gives it seven edges.
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end
    else
    begin
      blk_s1 <= blk_reg;
      blk_s2 <= blk_s1;
    end
  end

  // First word: the address byte picks which identity leads.
  always_comb
  begin
    if (kd_reg == fidsg_pkg::ID_STD)
      init_w = {MAKER_ID, DEV_ID};
    else if (sh_reg == fidsg_pkg::ORD_DEV_FIRST)
      init_w = {SHORT_ID, MAKER_ID, 8'h00};
    else
      init_w = {MAKER_ID, SHORT_ID, 8'h00};
    cur_w = go_reg ? ow_reg : init_w;
  end

  // Identity bits leave on falling edges, MSB first, and rotate to repeat.
  // Chip select high resets this logic, which releases the lines at once.
  always_ff @(negedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ow_reg <= 24'h000000;
      go_reg <= 1'b0;
      dq_o   <= 4'h0;
      dq_oe  <= 4'h0;
    end
    else if (lk_reg == fidsg_pkg::LK_OUT)
    begin
      go_reg <= 1'b1;
      case (kd_reg)
        fidsg_pkg::ID_DUAL:
        begin
          dq_o   <= {2'h0, cur_w[23:22]};
          ow_reg <= {cur_w[21:8], cur_w[23:22], 8'h00};
          dq_oe  <= fidsg_pkg::OE_DUAL;
        end
        fidsg_pkg::ID_QUAD:
        begin
          dq_o   <= cur_w[23:20];
          ow_reg <= {cur_w[19:8], cur_w[23:20], 8'h00};
          dq_oe  <= fidsg_pkg::OE_QUAD;
        end
        default:
        begin
          dq_o   <= {2'h0, cur_w[23], 1'b0};
          ow_reg <= {cur_w[22:0], cur_w[23]};
          dq_oe  <= fidsg_pkg::OE_STD;
        end
      endcase
    end
  end

  // The toggle crosses by three flops; only the later two form the event.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end
    else if (clk_en)
    begin
      tg_s1 <= tgl_reg;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  assign ev = tg_s2 ^ tg_s3;
  assign ers = (kind_reg != fidsg_pkg::KIND_PAGE);
  assign wait_end = (st_reg == fidsg_pkg::ST_WAIT) && (lat_reg == '0);
  assign resume = ev && (st_reg == fidsg_pkg::ST_SUSP) && (fop_reg == fidsg_pkg::OP_RESUME);

  // Decide whether an opcode is taken in the present state.
  always_comb
  begin
    acc = 1'b0;
    case (fop_reg)
      8'h05, 8'h35, 8'h15, 8'hab, 8'h66, 8'h99, 8'h00, 8'h48:
        acc = 1'b1;
      8'h03, 8'h0b, 8'h0d, 8'h3b, 8'h6b, 8'hbb, 8'hbd, 8'heb, 8'he7, 8'hed, 8'h0c, 8'h0e:
        acc = (st_reg == fidsg_pkg::ST_SUSP);
      8'h38, 8'hff, 8'h5a, 8'h9f, 8'h90, 8'h92, 8'h94, 8'h77, 8'hc0, 8'h7a:
        acc = (st_reg == fidsg_pkg::ST_SUSP);
      8'h3d, 8'h04:
        acc = (st_reg == fidsg_pkg::ST_SUSP);
      8'h06, 8'h02, 8'h32, 8'h42, 8'h39, 8'h98:
        acc = (st_reg == fidsg_pkg::ST_SUSP) && ers;
      8'h75:
        acc = (st_reg == fidsg_pkg::ST_BUSY);
      default:
        acc = 1'b0;
    endcase
    // With no operation running, every opcode goes on to the rest of the chip.
    if (st_reg == fidsg_pkg::ST_IDLE)
      acc = 1'b1;
  end

  // Suspend sequencing of the running program or erase.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg   <= fidsg_pkg::ST_IDLE;
      kind_reg <= fidsg_pkg::KIND_PAGE;
      base_reg <= 24'h000000;
      lat_reg  <= '0;
      hold     <= 1'b0;
    end
    else if (clk_en)
    begin
      case (st_reg)
        fidsg_pkg::ST_IDLE:
          if (op_start)
          begin
            st_reg   <= fidsg_pkg::ST_BUSY;
            kind_reg <= op_kind;
            base_reg <= op_addr;
          end
        fidsg_pkg::ST_BUSY:
          if (op_done)
            st_reg <= fidsg_pkg::ST_IDLE;
          else if (ev && fop_reg == fidsg_pkg::OP_SUSPEND)
          begin
            // The host must keep resume-to-suspend spacing; none is timed here.
            st_reg  <= fidsg_pkg::ST_WAIT;
            lat_reg <= ers ? CW'(ESL_CYCLES - 1) : CW'(PSL_CYCLES - 1);
          end
        fidsg_pkg::ST_WAIT:
          if (wait_end)
          begin
            st_reg <= fidsg_pkg::ST_SUSP;
            hold   <= 1'b1;
          end
          else
            lat_reg <= lat_reg - CW'(1);
        fidsg_pkg::ST_SUSP:
          if (resume)
          begin
            st_reg <= fidsg_pkg::ST_BUSY;
            hold   <= 1'b0;
          end
        default:
          st_reg <= fidsg_pkg::ST_IDLE;
      endcase
    end
  end

  // Status bits; where a clear and a set meet, the set is written last and wins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sr_o <= '0;
    else if (clk_en)
    begin
      if (wait_end)
      begin
        sr_o.write_enable_latch <= 1'b0;
        sr_o.write_in_progress  <= 1'b0;
        sr_o.suspend_flag       <= 1'b1;
      end
      if (st_reg == fidsg_pkg::ST_BUSY && op_done)
      begin
        sr_o.write_enable_latch <= 1'b0;
        sr_o.write_in_progress  <= 1'b0;
      end
      if (ev && acc && fop_reg == fidsg_pkg::OP_WRITE_DISABLE_COMMAND)
        sr_o.write_enable_latch <= 1'b0;
      if (ev && acc && fop_reg == fidsg_pkg::OP_WRITE_ENABLE_COMMAND)
        sr_o.write_enable_latch <= 1'b1;
      if (st_reg == fidsg_pkg::ST_IDLE && op_start)
        sr_o.write_in_progress <= 1'b1;
      if (resume)
      begin
        sr_o.write_enable_latch <= 1'b1;
        sr_o.write_in_progress  <= 1'b1;
        sr_o.suspend_flag       <= 1'b0;
      end
    end
  end

  // Verdict on each opcode, one pulse per frame.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_o <= '0;
    else if (clk_en)
    begin
      cmd_o.ok   <= ev && acc;
      cmd_o.drop <= ev && !acc;
      if (ev)
        cmd_o.op <= fop_reg;
    end
  end

  // Region hit for the suspended operation.
  always_comb
  begin
    case (kind_reg)
      fidsg_pkg::KIND_PAGE: hit = rd_addr[23:fidsg_pkg::PAGE_LSB] == base_reg[23:fidsg_pkg::PAGE_LSB];
      fidsg_pkg::KIND_SEC:  hit = rd_addr[23:fidsg_pkg::SEC_LSB] == base_reg[23:fidsg_pkg::SEC_LSB];
      fidsg_pkg::KIND_B32:  hit = rd_addr[23:fidsg_pkg::B32_LSB] == base_reg[23:fidsg_pkg::B32_LSB];
      default:              hit = rd_addr[23:fidsg_pkg::B64_LSB] == base_reg[23:fidsg_pkg::B64_LSB];
    endcase
  end

  // Array read permission and the identity block level.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ok   <= 1'b0;
      blk_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_ok   <= (st_reg == fidsg_pkg::ST_IDLE) || (st_reg == fidsg_pkg::ST_SUSP && !hit);
      blk_reg <= (st_reg == fidsg_pkg::ST_BUSY) || (st_reg == fidsg_pkg::ST_WAIT);
    end
  end

  property p_sus_set;
    @(posedge clk) disable iff (!rst_n)
    $rose(sr_o.suspend_flag) |-> !sr_o.write_enable_latch && $past(st_reg) == fidsg_pkg::ST_WAIT;
  endproperty
  a_sus_set: assert property (p_sus_set) else $error("Suspend flag set out of turn");

  property p_sus_state;
    @(posedge clk) disable iff (!rst_n)
    sr_o.suspend_flag |-> st_reg == fidsg_pkg::ST_SUSP && hold;
  endproperty
  a_sus_state: assert property (p_sus_state) else $error("Suspend flag without suspend");

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && resume) |=> sr_o.write_enable_latch && sr_o.write_in_progress && !sr_o.suspend_flag;
  endproperty
  a_resume: assert property (p_resume) else $error("Resume status wrong");

  property p_free;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && ev && st_reg == fidsg_pkg::ST_WAIT && fop_reg == 8'h05) |=> cmd_o.ok;
  endproperty
  a_free: assert property (p_free) else $error("Status read refused in wait");

  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && ev && st_reg == fidsg_pkg::ST_SUSP && !ers && fop_reg == fidsg_pkg::OP_WRITE_ENABLE_COMMAND)
      |=> cmd_o.drop && $stable(sr_o);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Write enable taken in program suspend");

  property p_erase_only;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && ev && st_reg == fidsg_pkg::ST_SUSP && ers && fop_reg == 8'h02) |=> cmd_o.ok;
  endproperty
  a_erase_only: assert property (p_erase_only) else $error("Program refused in erase suspend");

  property p_busy_id;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && ev && st_reg == fidsg_pkg::ST_BUSY && fop_reg == fidsg_pkg::OP_STD_ID) |=> cmd_o.drop;
  endproperty
  a_busy_id: assert property (p_busy_id) else $error("Identity read taken while busy");

  property p_region;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && st_reg == fidsg_pkg::ST_SUSP && hit) |=> !rd_ok;
  endproperty
  a_region: assert property (p_region) else $error("Frozen region readable");

  property p_alternate;
    @(negedge sclk) disable iff (!lrst_n)
    (kd_reg == fidsg_pkg::ID_QUAD && go_reg && $past(go_reg, 4)) |-> dq_o == $past(dq_o, 4);
  endproperty
  a_alternate: assert property (p_alternate) else $error("Quad identities do not repeat");

  c_suspend: cover property (@(posedge clk) disable iff (!rst_n) $rose(sr_o.suspend_flag));
  c_resume: cover property (@(posedge clk) disable iff (!rst_n) clk_en && resume);
  c_quad_out: cover property (@(negedge sclk) disable iff (!lrst_n) dq_oe == fidsg_pkg::OE_QUAD);

endmodule : fidsg_top

/* testbench/fidsg_host_model.sv */
`timescale 1ns/1ps
// Host controller model; sclk moves only inside frames, 48 ns period.
module fidsg_host_model (
  output logic            sclk,
  output logic            chip_select_n,
  output logic      [3:0] dq_i,
  input  wire logic [3:0] dq_o,
  input  wire logic [3:0] dq_oe
);
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    dq_i = 4'h0;
  end
  // Data changes while sclk is low and holds over the rising edge.
  task automatic put(input logic [3:0] v);
    dq_i = v;
    #24 sclk = 1'b1;
    #24 sclk = 1'b0;
  endtask : put
  // One frame: opcode, then dummies and address at width wi, then nout chunks of width wo.
  task automatic xfer(input logic [7:0] op, input int wi, input logic [7:0] adr,
                      input int wo, input int nout, output logic [31:0] got, output logic oe);
    got = 32'h0;
    oe = 1'b0;
    chip_select_n = 1'b0;
    for (int i = 7; i >= 0; i--)
      put({3'h0, op[i]});
    for (int i = 24 - wi; wi > 0 && i >= 0; i -= wi)
      put(4'(({16'h0000, adr} >> i) & ((1 << wi) - 1)));
    for (int i = 0; i < nout; i++)
    begin
      // Released lines toggle so that a stale level never looks valid.
      dq_i = ~dq_i;
      #24 sclk = 1'b1;
      oe |= |dq_oe;
      got = (got << wo) | ((wo == 1) ? 32'(dq_o[1]) : 32'(dq_o & 4'((1 << wo) - 1)));
      #24 sclk = 1'b0;
    end
    chip_select_n = 1'b1;
    #30;
  endtask : xfer
endmodule : fidsg_host_model

/* testbench/test_flash_id_read_and_suspend_gate.sv */
`timescale 1ns/1ps
module test_flash_id_read_and_suspend_gate;
  localparam int          LAT = 400;       // Long enough to send frames inside the wait.
  localparam int          RSL = 20;        // Host resume-to-suspend spacing, arbitrary value.
  localparam logic [7:0]  MK  = 8'h3c;     // Arbitrary value.
  localparam logic [15:0] DV  = 16'h4d2e;  // Arbitrary value.
  localparam logic [7:0]  SH  = 8'h6b;     // Arbitrary value.
  logic                  clk, rst_n, op_start, op_done, rd_ok, hold, sclk, chip_select_n, oe;
  logic                  clk_en;          // Core clock enable, dropped once to freeze the core.
  logic [1:0]            op_kind;
  logic [23:0]           op_addr, rd_addr;
  logic [3:0]            dq_i, dq_o, dq_oe;
  logic [31:0]           got;
  fidsg_pkg::fidsg_sr_t  sr_o;
  fidsg_pkg::fidsg_cmd_t cmd_o;
  int                    n_errors = 0, checks_done = 0, n_ok = 0, n_drop = 0;
  // Reads and mode codes accepted in both suspend kinds, then erase-only writes.
  logic [7:0] both_l [18] = '{8'h03, 8'h0b, 8'h0d, 8'h3b, 8'h6b, 8'hbb, 8'hbd, 8'heb, 8'he7,
                              8'hed, 8'h0c, 8'h0e, 8'h38, 8'hff, 8'h5a, 8'h77, 8'hc0, 8'h90};
  logic [7:0] ers_l [6] = '{8'h06, 8'h02, 8'h32, 8'h42, 8'h39, 8'h98};
  fidsg_top #(.PSL_CYCLES(LAT), .ESL_CYCLES(LAT), .MAKER_ID(MK), .DEV_ID(DV), .SHORT_ID(SH))
  u_fidsg_top (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk),
    .chip_select_n(chip_select_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done),
    .rd_addr(rd_addr), .rd_ok(rd_ok), .hold(hold), .sr_o(sr_o), .cmd_o(cmd_o));
  fidsg_host_model u_fidsg_host_model (.sclk(sclk), .chip_select_n(chip_select_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Verdict pulses are single cycles, so they are counted on every edge.
  always @(posedge clk)
  begin
    n_ok += (cmd_o.ok === 1'b1);
    n_drop += (cmd_o.drop === 1'b1);
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %0t: saw %h wanted %h", $time, g, e);
    end
  endtask : chk
  // Sends a bare opcode and checks whether the core accepted or dropped it.
  task automatic cmd(input logic [7:0] op, input logic e);
    int k;
    int d;
    k = n_ok;
    d = n_drop;
    u_fidsg_host_model.xfer(op, 0, 8'h00, 1, 0, got, oe);
    for (int i = 0; i < 20 && n_ok + n_drop == k + d; i++)
      @(posedge clk);
    chk(32'(n_ok - k), 32'(e));
    chk(32'(n_drop - d), 32'(!e));
    chk(32'(cmd_o.op), 32'(op));
    if (n_ok + n_drop == k + d)
      end_sim();
  endtask : cmd
  task automatic id(input logic [7:0] op, input int wi, input logic [7:0] a, input int wo,
                    input int n, input logic [31:0] e);
    u_fidsg_host_model.xfer(op, wi, a, wo, n, got, oe);
    chk(got, e);
    chk(32'(oe), 32'h1);
  endtask : id
  task automatic pulse(input logic s, input logic [1:0] k, input logic [23:0] a);
    @(posedge clk);
    op_start <= s;
    op_done <= !s;
    op_kind <= k;
    op_addr <= a;
    @(posedge clk);
    op_start <= 1'b0;
    op_done <= 1'b0;
  endtask : pulse
  task automatic rd(input logic [23:0] a, input logic e);
    @(posedge clk);
    rd_addr <= a;
    repeat (3) @(posedge clk);
    chk(32'(rd_ok), 32'(e));
  endtask : rd
  // Suspends the running operation and waits, bounded, for the flag.
  task automatic susp;
    cmd(fidsg_pkg::OP_SUSPEND, 1'b1);
    cmd(8'h03, 1'b0);
    cmd(8'h66, 1'b1);
    cmd(8'h05, 1'b1);
    for (int i = 0; i < LAT && sr_o.suspend_flag !== 1'b1; i++)
      @(posedge clk);
    chk({hold, sr_o}, 32'h18000);
    // A suspend that never completes would hang every later scenario.
    if (sr_o.suspend_flag !== 1'b1)
      end_sim();
  endtask : susp
  task automatic t_ids;
    id(fidsg_pkg::OP_STD_ID, 0, 8'h00, 1, 5, 32'(MK[7:3]));
    id(fidsg_pkg::OP_STD_ID, 0, 8'h00, 1, 24, {8'h00, MK, DV});
    id(fidsg_pkg::OP_DUAL_ID, 2, 8'h00, 2, 16, {MK, SH, MK, SH});
    id(fidsg_pkg::OP_DUAL_ID, 2, 8'h01, 2, 16, {SH, MK, SH, MK});
    id(fidsg_pkg::OP_QUAD_ID, 4, 8'h00, 4, 8, {MK, SH, MK, SH});
    id(fidsg_pkg::OP_QUAD_ID, 4, 8'h01, 4, 8, {SH, MK, SH, MK});
  endtask : t_ids
  task automatic t_prog;
    pulse(1'b1, fidsg_pkg::KIND_PAGE, 24'h012345);
    u_fidsg_host_model.xfer(fidsg_pkg::OP_STD_ID, 0, 8'h00, 1, 24, got, oe);
    chk(32'(oe), 32'h0);
    cmd(fidsg_pkg::OP_STD_ID, 1'b0);
    cmd(8'h05, 1'b1);
    susp();
    rd(24'h0123ff, 1'b0);
    rd(24'h012400, 1'b1);
    foreach (ers_l[i])
      cmd(ers_l[i], 1'b0);
    cmd(8'h44, 1'b0);
    chk({hold, sr_o}, 32'h18000);
    foreach (both_l[i])
      cmd(both_l[i], 1'b1);
    cmd(8'h3d, 1'b1);
    cmd(fidsg_pkg::OP_RESUME, 1'b1);
    chk({hold, sr_o}, 32'h00003);
    pulse(1'b0, 2'h0, 24'h0);
  endtask : t_prog
  task automatic t_erase;
    pulse(1'b1, fidsg_pkg::KIND_SEC, 24'h020000);
    susp();
    rd(24'h020fff, 1'b0);
    rd(24'h021000, 1'b1);
    // With the enable low the core must hold its last read verdict.
    clk_en <= 1'b0;
    rd(24'h020fff, 1'b1);
    clk_en <= 1'b1;
    id(fidsg_pkg::OP_QUAD_ID, 4, 8'h01, 4, 8, {SH, MK, SH, MK});
    foreach (ers_l[i])
      cmd(ers_l[i], 1'b1);
    cmd(fidsg_pkg::OP_RESUME, 1'b1);
    chk({hold, sr_o}, 32'h00003);
    pulse(1'b0, 2'h0, 24'h0);
  endtask : t_erase
  // Block erase suspend, resumed and suspended again after the host spacing.
  task automatic t_blk(input logic [1:0] k, input logic [23:0] a, input logic [23:0] f,
                       input logic [23:0] o);
    pulse(1'b1, k, a);
    susp();
    rd(f, 1'b0);
    rd(o, 1'b1);
    cmd(fidsg_pkg::OP_RESUME, 1'b1);
    // The host keeps the resume-to-suspend spacing before suspending again.
    repeat (RSL) @(posedge clk);
    susp();
    cmd(fidsg_pkg::OP_RESUME, 1'b1);
    chk({hold, sr_o}, 32'h00003);
    pulse(1'b0, 2'h0, 24'h0);
  endtask : t_blk
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    op_start = 1'b0;
    op_done = 1'b0;
    op_kind = 2'h0;
    op_addr = 24'h0;
    rd_addr = 24'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_ids();
    t_prog();
    t_erase();
    t_blk(fidsg_pkg::KIND_B32, 24'h038000, 24'h03ffff, 24'h030000);
    t_blk(fidsg_pkg::KIND_B64, 24'h040000, 24'h04ffff, 24'h050000);
    end_sim();
  end
endmodule : test_flash_id_read_and_suspend_gate
